//--- cmb_pkg.sv
package cmb_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int BIT_TIME_NS = 2000;
	localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
	localparam int SAMPLE_CYCLE = BIT_CYCLES / 2;
	localparam int CNT_W = $clog2(BIT_CYCLES);
	localparam int FRAME_BYTES = 13;
	localparam int FRAME_BITS = FRAME_BYTES * 8;
	localparam int TX_BUFS = 3;
	localparam int LOCAL_PRIORITY_FIELD_WORD = 13;
	localparam int EOF_BITS = 10;
	localparam logic [11:0] INST0_BASE = 12'h000;
	localparam logic [11:0] INST1_BASE = 12'h200;
	localparam logic [11:0] INST2_BASE = 12'h100;
	localparam logic [7:0] OFF_RXWIN = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h34;
	localparam logic [7:0] OFF_RFLAG = 8'h38;
	localparam logic [7:0] OFF_TFLAG = 8'h3C;
	localparam logic [7:0] OFF_ACC = 8'h78;
	localparam logic [7:0] OFF_PORT_CTL = 8'hB8;
	localparam logic [7:0] OFF_PORT_DIR = 8'hF8;
	localparam logic [2:0] TXE_RESET = 3'h7;
	localparam logic [7:0] ACC_MASK_RESET = 8'h00;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_DATA = 4'h2,
		ST_ACK = 4'h4,
		ST_EOF = 4'h8
	} cmb_state_e;
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] off;
	} cmb_addr_s;
	typedef struct packed {
		logic ovr_int_en;
		logic rx_int_en;
		logic loopback;
	} cmb_ctrl_s;
endpackage

//--- cmb_bit_timing.sv
`timescale 1ns/10ps
`default_nettype none
module cmb_bit_timing (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic rx_pin,
	input wire logic hard_sync_en,
	output logic rx_level,
	output logic bit_start,
	output logic sample
);
	logic [1:0] sync;
	logic prev;
	logic [cmb_pkg::CNT_W-1:0] cnt;

	// Two stages before any logic sees the pin
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync <= 2'h3;
			prev <= 1'b1;
		end else begin
			sync <= {sync[0], rx_pin};
			prev <= sync[1];
		end
	end

	// Hard sync on a falling edge only while idle; no resync inside a frame
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= '0;
		end else if (hard_sync_en && prev && !sync[1]) begin
			cnt <= cmb_pkg::CNT_W'(1);
		end else if (cnt == cmb_pkg::CNT_W'(cmb_pkg::BIT_CYCLES - 1)) begin
			cnt <= '0;
		end else begin
			cnt <= cnt + cmb_pkg::CNT_W'(1);
		end
	end

	assign rx_level = sync[1];
	assign bit_start = (cnt == '0);
	assign sample = (cnt == cmb_pkg::CNT_W'(cmb_pkg::SAMPLE_CYCLE));

	bit_period_a: assert property (@(posedge hclk) disable iff (!hresetn)
		bit_start && !hard_sync_en |-> ##(cmb_pkg::BIT_CYCLES) bit_start)
		else $error("bit period wrong");
endmodule
`default_nettype wire

//--- cmb_top.sv
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module cmb_top #(
	parameter logic [1:0] INSTANCE = 2'h0
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [7:0] port_in,
	output logic [7:0] port_out,
	output logic [7:0] port_oe,
	output logic rx_irq,
	output logic err_irq
);
	cmb_pkg::cmb_addr_s aph;
	cmb_pkg::cmb_ctrl_s ctrl;
	cmb_pkg::cmb_state_e state;
	logic [11:0] base;
	logic [11:0] rel;
	logic hit;
	logic [1:0] rbuf;
	logic [1:0] wbuf;
	logic [31:0] rdata;
	logic wr;
	logic [7:0] acc_code;
	logic [7:0] acc_mask;
	logic [7:0] pctl;
	logic [7:0] pdir;
	logic receive_full_flag;
	logic ovr;
	logic bg_full;
	logic [2:0] transmit_empty_flag;
	logic [7:0] fg [cmb_pkg::FRAME_BYTES];
	logic [7:0] bg [cmb_pkg::FRAME_BYTES];
	logic [7:0] tx_mem [cmb_pkg::TX_BUFS][cmb_pkg::LOCAL_PRIORITY_FIELD_WORD + 1];
	logic [cmb_pkg::FRAME_BITS-1:0] shift;
	logic [6:0] bitcnt;
	logic tx_active;
	logic own;
	logic drive;
	logic [1:0] tx_sel;
	logic [1:0] best;
	logic any_pend;
	logic tx_bit;
	logic rx_level;
	logic bit_start;
	logic sample;
	logic rx_bit;
	logic start;
	logic tx_done;
	logic commit;
	logic accept;
	logic load_new;
	logic release_bg;
	logic clr_rxf;
	logic clr_ovr;
	logic [2:0] clr_txe;

	// Instance windows are 256 bytes wide
	assign base = (INSTANCE == 2'h1) ? cmb_pkg::INST1_BASE :
		(INSTANCE == 2'h2) ? cmb_pkg::INST2_BASE : cmb_pkg::INST0_BASE;
	assign rel = haddr[11:0] - base;
	assign hit = hsel && htrans[1] && hready && (hsize == 3'h2) && (rel[11:8] == 4'h0);
	assign rbuf = 2'(rel[7:6] - 2'h1);
	assign wbuf = 2'(aph.off[7:6] - 2'h1);
	assign wr = aph.valid && aph.write;

	cmb_bit_timing u_timing (
		.hclk(hclk),
		.hresetn(hresetn),
		.rx_pin(port_in[0]),
		.hard_sync_en((state == cmb_pkg::ST_IDLE) && !tx_active),
		.rx_level(rx_level),
		.bit_start(bit_start),
		.sample(sample)
	);

	// In loop-back the receiver hears only the internal transmit level
	assign rx_bit = ctrl.loopback ? drive : rx_level;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aph <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			aph.valid <= hit;
			aph.write <= hwrite;
			aph.off <= rel[7:0];
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Read data is fetched in the address phase, so no wait states
	always_comb begin
		rdata = 32'h0;
		if (rel[7:6] == 2'h0 && rel[5:2] < 4'(cmb_pkg::FRAME_BYTES)) begin
			rdata[7:0] = fg[rel[5:2]];
		end else if (rel[7:0] == cmb_pkg::OFF_CTRL) begin
			rdata[2:0] = ctrl;
		end else if (rel[7:0] == cmb_pkg::OFF_RFLAG) begin
			rdata[2:0] = {bg_full, ovr, receive_full_flag};
		end else if (rel[7:0] == cmb_pkg::OFF_TFLAG) begin
			rdata[3:0] = {tx_active, transmit_empty_flag};
		end else if (rel[7:0] == cmb_pkg::OFF_ACC) begin
			rdata[15:0] = {acc_mask, acc_code};
		end else if (rel[7:0] == cmb_pkg::OFF_PORT_CTL) begin
			rdata[7:0] = {pctl[7:2], 2'h0};
		end else if (rel[7:0] == cmb_pkg::OFF_PORT_DIR) begin
			rdata[7:0] = {pdir[7:2], 2'h0};
		end else if (rel[7:6] != 2'h0 && rel[5:2] <= 4'(cmb_pkg::LOCAL_PRIORITY_FIELD_WORD)) begin
			rdata[7:0] = tx_mem[rbuf][rel[5:2]];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
		end else if (hit && !hwrite) begin
			hrdata <= rdata;
		end else begin
			hrdata <= 32'h0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= '0;
			acc_code <= 8'h00;
			acc_mask <= cmb_pkg::ACC_MASK_RESET;
			pctl <= 8'h00;
			pdir <= 8'h00;
		end else if (wr) begin
			if (aph.off == cmb_pkg::OFF_CTRL) begin
				ctrl <= hwdata[2:0];
			end
			if (aph.off == cmb_pkg::OFF_ACC) begin
				acc_code <= hwdata[7:0];
				acc_mask <= hwdata[15:8];
			end
			if (aph.off == cmb_pkg::OFF_PORT_CTL) begin
				pctl <= hwdata[7:0];
			end
			if (aph.off == cmb_pkg::OFF_PORT_DIR) begin
				pdir <= hwdata[7:0];
			end
		end
	end

	// A buffer can be loaded only while its empty flag is set
	always_ff @(posedge hclk) begin
		if (wr && aph.off[7:6] != 2'h0 && aph.off[5:2] <= 4'(cmb_pkg::LOCAL_PRIORITY_FIELD_WORD)
			&& transmit_empty_flag[wbuf]) begin
			tx_mem[wbuf][aph.off[5:2]] <= hwdata[7:0];
		end
	end

	assign clr_rxf = wr && (aph.off == cmb_pkg::OFF_RFLAG) && hwdata[0];
	assign clr_ovr = wr && (aph.off == cmb_pkg::OFF_RFLAG) && hwdata[1];
	assign clr_txe = (wr && aph.off == cmb_pkg::OFF_TFLAG) ? hwdata[2:0] : 3'h0;

	// Ties go to the lower buffer index
	always_comb begin
		any_pend = 1'b0;
		best = 2'h0;
		for (int i = 0; i < cmb_pkg::TX_BUFS; i++) begin
			if (!transmit_empty_flag[i] && (!any_pend ||
				tx_mem[i][cmb_pkg::LOCAL_PRIORITY_FIELD_WORD] < tx_mem[best][cmb_pkg::LOCAL_PRIORITY_FIELD_WORD])) begin
				any_pend = 1'b1;
				best = 2'(i);
			end
		end
	end

	assign start = (state == cmb_pkg::ST_IDLE) && bit_start && any_pend && !tx_active;
	assign tx_bit = tx_mem[tx_sel][bitcnt[6:3]][~bitcnt[2:0]];
	assign tx_done = (state == cmb_pkg::ST_ACK) && sample && tx_active && !rx_bit;
	assign commit = (state == cmb_pkg::ST_EOF) && sample &&
		(bitcnt == 7'(cmb_pkg::EOF_BITS - 1));
	assign accept = (((shift[cmb_pkg::FRAME_BITS-1 -: 8] ^ acc_code) & acc_mask) == 8'h00)
		&& (!own || ctrl.loopback);

	// Bit stuffing and CRC are not handled; frames are raw 13-byte images
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= cmb_pkg::ST_IDLE;
			bitcnt <= 7'h00;
			tx_active <= 1'b0;
			tx_sel <= 2'h0;
			own <= 1'b0;
			shift <= '0;
		end else begin
			unique case (state)
				cmb_pkg::ST_IDLE: begin
					if (start) begin
						tx_active <= 1'b1;
						tx_sel <= best;
					end
					if (sample && !rx_bit) begin
						state <= cmb_pkg::ST_DATA;
						bitcnt <= 7'h00;
					end
				end
				cmb_pkg::ST_DATA: begin
					if (sample) begin
						shift <= {shift[cmb_pkg::FRAME_BITS-2:0], rx_bit};
						if (tx_active && rx_bit != tx_bit) begin
							tx_active <= 1'b0;
						end
						if (bitcnt == 7'(cmb_pkg::FRAME_BITS - 1)) begin
							state <= cmb_pkg::ST_ACK;
						end
						bitcnt <= bitcnt + 7'h01;
					end
				end
				cmb_pkg::ST_ACK: begin
					if (sample) begin
						own <= tx_active;
						if (tx_active && rx_bit) begin
							tx_active <= 1'b0;
						end
						state <= cmb_pkg::ST_EOF;
						bitcnt <= 7'h00;
					end
				end
				cmb_pkg::ST_EOF: begin
					if (sample) begin
						bitcnt <= bitcnt + 7'h01;
						if (commit) begin
							state <= cmb_pkg::ST_IDLE;
							tx_active <= 1'b0;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			drive <= 1'b1;
		end else if (bit_start) begin
			unique case (state)
				cmb_pkg::ST_IDLE: drive <= !start;
				cmb_pkg::ST_DATA: drive <= !tx_active || tx_bit;
				cmb_pkg::ST_ACK: drive <= tx_active && !ctrl.loopback;
				cmb_pkg::ST_EOF: drive <= 1'b1;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_out <= 8'h02;
			port_oe <= 8'h02;
		end else begin
			port_out <= {pctl[7:2], ctrl.loopback || drive, 1'b0};
			port_oe <= {pdir[7:2], 2'h2};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			transmit_empty_flag <= cmb_pkg::TXE_RESET;
		end else begin
			transmit_empty_flag <= (transmit_empty_flag & ~clr_txe) | (tx_done ? (3'h1 << tx_sel) : 3'h0);
		end
	end

	// Overflow frames stay out of the background stage, so its content is kept
	assign load_new = commit && accept && !receive_full_flag && !bg_full;
	assign release_bg = bg_full && (!receive_full_flag || clr_rxf);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			receive_full_flag <= 1'b0;
			bg_full <= 1'b0;
			ovr <= 1'b0;
		end else begin
			if (load_new || release_bg) begin
				receive_full_flag <= 1'b1;
			end else if (clr_rxf) begin
				receive_full_flag <= 1'b0;
			end
			if (release_bg) begin
				bg_full <= 1'b0;
			end else if (commit && accept && receive_full_flag) begin
				bg_full <= 1'b1;
			end
			if (commit && accept && bg_full) begin
				ovr <= 1'b1;
			end else if (clr_ovr) begin
				ovr <= 1'b0;
			end
		end
	end

	generate
		for (genvar i = 0; i < cmb_pkg::FRAME_BYTES; i++) begin : g_rx
			always_ff @(posedge hclk) begin
				if (commit && !bg_full) begin
					bg[i] <= shift[cmb_pkg::FRAME_BITS-1-8*i -: 8];
				end
				if (load_new) begin
					fg[i] <= shift[cmb_pkg::FRAME_BITS-1-8*i -: 8];
				end else if (release_bg) begin
					fg[i] <= bg[i];
				end
			end
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_irq <= 1'b0;
			err_irq <= 1'b0;
		end else begin
			rx_irq <= receive_full_flag && ctrl.rx_int_en;
			err_irq <= ovr && ctrl.ovr_int_en;
		end
	end

	rxf_copy_a: assert property (@(posedge hclk) disable iff (!hresetn)
		load_new |=> receive_full_flag && (fg[0] == $past(shift[cmb_pkg::FRAME_BITS-1 -: 8])))
		else $error("accepted frame not copied");
	own_frame_a: assert property (@(posedge hclk) disable iff (!hresetn)
		commit && own && !ctrl.loopback && !receive_full_flag && !bg_full |=> !receive_full_flag)
		else $error("own frame reached foreground");
	overrun_a: assert property (@(posedge hclk) disable iff (!hresetn)
		commit && accept && bg_full |=> ovr && $stable(bg[0]))
		else $error("overrun not flagged");
	bg_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		bg_full && receive_full_flag && !clr_rxf |=> $stable(bg[1]) && bg_full)
		else $error("full background changed");
	rx_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
		receive_full_flag && ctrl.rx_int_en ##1 ctrl.rx_int_en |-> rx_irq)
		else $error("receive interrupt missing");
	ack_own_a: assert property (@(posedge hclk) disable iff (!hresetn)
		state == cmb_pkg::ST_ACK && bit_start && tx_active && !ctrl.loopback |=> drive)
		else $error("own frame acknowledged");
	local_priority_field_order_a: assert property (@(posedge hclk) disable iff (!hresetn)
		start |=> tx_active && (transmit_empty_flag[0] ||
			tx_mem[tx_sel][cmb_pkg::LOCAL_PRIORITY_FIELD_WORD] <= tx_mem[0][cmb_pkg::LOCAL_PRIORITY_FIELD_WORD]))
		else $error("wrong buffer scheduled");
	txe_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
		tx_done |=> transmit_empty_flag[$past(tx_sel)])
		else $error("empty flag not set after send");
	pin_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
		port_oe[1] && !port_oe[0] && !port_out[0])
		else $error("CAN pin directions wrong");
endmodule
`default_nettype wire

//--- cmb_can_node.sv
`timescale 1ns/10ps
`default_nettype none
module cmb_can_node (
	input wire logic hclk,
	input wire logic bus,
	output logic drv
);
	logic [103:0] got;
	logic ack_seen;
	logic busy;
	int rx_frames;
	initial begin
		drv = 1'b1;
		busy = 1'b0;
		ack_seen = 1'b0;
		rx_frames = 0;
	end
	task automatic bit_out(input logic b);
		@(posedge hclk) drv <= b;
		repeat (19) @(posedge hclk);
	endtask
	// Released level is recessive, as the bus pull-up leaves it
	task automatic send(input logic [103:0] f);
		busy = 1'b1;
		bit_out(1'b0);
		for (int i = 103; i >= 0; i--) begin
			bit_out(f[i]);
		end
		@(posedge hclk) drv <= 1'b1;
		repeat (10) @(posedge hclk);
		ack_seen = ~bus;
		repeat (210) @(posedge hclk);
		busy = 1'b0;
	endtask
	// Short EOF wait so a back-to-back frame from the block is not missed
	always begin
		@(negedge bus);
		if (!busy) begin
			repeat (10) @(posedge hclk);
			for (int i = 103; i >= 0; i--) begin
				repeat (20) @(posedge hclk);
				got[i] = bus;
			end
			repeat (10) @(posedge hclk);
			drv <= 1'b0;
			repeat (20) @(posedge hclk);
			drv <= 1'b1;
			repeat (170) @(posedge hclk);
			rx_frames++;
		end
	end
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_irq, err_irq, node_drv, can_bus;
	logic [31:0] haddr, hwdata, hrdata, d;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] port_out, port_oe;
	logic [103:0] g;
	int err_total, samples_checked;
	int cycles = 0;
	assign can_bus = port_out[1] & node_drv;
	cmb_top #(.INSTANCE(2'h0)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.port_in({7'h00, can_bus}), .port_out(port_out), .port_oe(port_oe),
		.rx_irq(rx_irq), .err_irq(err_irq));
	cmb_can_node i_node (.hclk(hclk), .bus(can_bus), .drv(node_drv));
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	task automatic chk(input string n, input logic [103:0] e, input logic [103:0] s);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [31:0] x;
		ahb(1'b1, a, v, x);
	endtask
	task automatic rdw(input logic [7:0] a);
		ahb(1'b0, a, 32'h00000000, d);
	endtask
	function automatic logic [103:0] mkf(input logic [7:0] s);
		for (int i = 0; i < 13; i++) begin
			mkf[103 - 8 * i -: 8] = s + 8'(i * 37);
		end
	endfunction
	task automatic rdframe;
		for (int i = 0; i < 13; i++) begin
			rdw(8'(i * 4));
			g[103 - 8 * i -: 8] = d[7:0];
		end
	endtask
	task automatic load(input logic [7:0] b, input logic [103:0] f, input logic [7:0] p);
		for (int i = 0; i < 13; i++) begin
			wr(b + 8'(i * 4), {24'h000000, f[103 - 8 * i -: 8]});
		end
		wr(b + 8'h34, {24'h000000, p});
	endtask
	// A wait that runs out is counted as a mismatch
	task automatic wait_tx;
		d = 32'h00000000;
		for (int k = 0; k < 2000 && d[2:0] !== 3'h7; k++) rdw(cmb_pkg::OFF_TFLAG);
		chk("tx done", 3'h7, d[2:0]);
	endtask
	task automatic wait_rx(input int n);
		for (int k = 0; k < 3000 && i_node.rx_frames == n; k++) @(posedge hclk);
		chk("frame count", n + 1, i_node.rx_frames);
	endtask
	task automatic t_reset;
		#1 chk("port_out", 8'h02, port_out);
		chk("hresp", 1'b0, hresp);
		chk("hreadyout", 1'b1, hreadyout);
		chk("port_oe", 8'h02, port_oe);
		rdw(cmb_pkg::OFF_RFLAG);
		chk("rflag", 32'h0, d);
		rdw(cmb_pkg::OFF_TFLAG);
		chk("tflag", 32'h7, d);
		wr(8'hFC, 32'hFFFFFFFF);
		rdw(8'hFC);
		chk("unmapped", 32'h0, d);
		wr(cmb_pkg::OFF_PORT_CTL, 32'hFC);
		wr(cmb_pkg::OFF_PORT_DIR, 32'hFC);
		repeat (2) @(posedge hclk);
		#1 chk("port_out", 8'hFE, port_out);
		chk("port_oe", 8'hFE, port_oe);
		$display("test reset done");
	endtask
	task automatic t_rx(input logic [103:0] f1);
		wr(cmb_pkg::OFF_CTRL, 32'h6);
		i_node.send(f1);
		repeat (5) @(posedge hclk);
		chk("ack", 1'b1, i_node.ack_seen);
		rdw(cmb_pkg::OFF_RFLAG);
		chk("rflag", 2'h1, d[1:0]);
		chk("rx_irq", 1'b1, rx_irq);
		rdframe;
		chk("rx frame", f1, g);
		i_node.send(mkf(8'h22));
		repeat (5) @(posedge hclk);
		rdw(cmb_pkg::OFF_RFLAG);
		chk("rflag", 3'h5, d[2:0]);
		rdframe;
		chk("foreground kept", f1, g);
		i_node.send(mkf(8'h33));
		repeat (5) @(posedge hclk);
		rdw(cmb_pkg::OFF_RFLAG);
		chk("overrun", 2'h3, d[1:0]);
		chk("err_irq", 1'b1, err_irq);
		rdframe;
		chk("foreground kept", f1, g);
		$display("test receive done");
	endtask
	task automatic t_tx_full(input logic [103:0] fa, input logic [103:0] fb);
		int n;
		load(8'h80, fa, 8'h05);
		load(8'hC0, fb, 8'h03);
		n = i_node.rx_frames;
		wr(cmb_pkg::OFF_TFLAG, 32'h6);
		wait_rx(n);
		chk("first sent", fb, i_node.got);
		wait_rx(n + 1);
		chk("second sent", fa, i_node.got);
		wait_tx;
		chk("tflag", 3'h7, d[2:0]);
		wr(cmb_pkg::OFF_RFLAG, 32'h3);
		// Releasing the foreground moves the waiting background frame up
		rdw(cmb_pkg::OFF_RFLAG);
		chk("rflag moved", 3'h1, d[2:0]);
		rdframe;
		chk("second frame", mkf(8'h22), g);
		wr(cmb_pkg::OFF_RFLAG, 32'h1);
		rdw(cmb_pkg::OFF_RFLAG);
		chk("rflag cleared", 2'h0, d[1:0]);
		chk("err_irq", 1'b0, err_irq);
		$display("test transmit done");
	endtask
	task automatic t_loop(input logic [103:0] fc);
		wr(cmb_pkg::OFF_CTRL, 32'h2);
		load(8'h40, fc, 8'h00);
		wr(cmb_pkg::OFF_TFLAG, 32'h1);
		wait_tx;
		repeat (250) @(posedge hclk);
		rdw(cmb_pkg::OFF_RFLAG);
		chk("own frame", 1'b0, d[0]);
		chk("rx_irq", 1'b0, rx_irq);
		wr(cmb_pkg::OFF_CTRL, 32'h3);
		wr(cmb_pkg::OFF_TFLAG, 32'h1);
		wait_tx;
		d = 32'h0;
		for (int k = 0; k < 300 && d[0] !== 1'b1; k++) rdw(cmb_pkg::OFF_RFLAG);
		chk("loop rflag", 1'b1, d[0]);
		rdframe;
		chk("loop frame", fc, g);
		chk("rx_irq", 1'b1, rx_irq);
		wr(cmb_pkg::OFF_CTRL, 32'h1);
		rdw(cmb_pkg::OFF_RFLAG);
		chk("poll rflag", 1'b1, d[0]);
		chk("rx_irq masked", 1'b0, rx_irq);
		$display("test loop-back done");
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Seven frames of about 2300 cycles each, plus register traffic
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			err_total++;
			results;
		end
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		err_total = 0;
		samples_checked = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_rx(mkf(8'h11));
		t_tx_full(mkf(8'hA5), mkf(8'h5A));
		t_loop(mkf(8'hC3));
		results;
	end
endmodule
`default_nettype wire
